// ---- design/gpr_pkg.sv ----
/*
  Constants, register map and encodings for the 16-pin port register bank.
  Assumes a 32-bit APB master that only makes whole-word accesses.
*/
package gpr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] GPR_OFS_CFG_LOW   = 8'h00;
  localparam logic [7:0] GPR_OFS_CFG_HIGH  = 8'h04;
  localparam logic [7:0] GPR_OFS_IN_LEVEL  = 8'h08;
  localparam logic [7:0] GPR_OFS_OUT_LEVEL = 8'h0C;
  localparam logic [7:0] GPR_OFS_SET_CLR   = 8'h10;
  localparam logic [7:0] GPR_OFS_CLR_ONLY  = 8'h14;
  localparam logic [7:0] GPR_OFS_PROTECT   = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // widths and field positions
  localparam int GPR_PINS       = 16;
  localparam int GPR_PINS_CFG   = 8;
  localparam int GPR_FLD_W      = 4;
  localparam int GPR_MODE_LSB   = 0;
  localparam int GPR_FUNC_LSB   = 2;
  localparam int GPR_CLR_LSB    = 16;
  localparam int GPR_SEQ_BIT    = 16;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [31:0] GPR_RST_CFG   = 32'h4444_4444;
  localparam logic [15:0] GPR_RST_OUT   = 16'h0000;
  localparam logic [15:0] GPR_RST_LOCK  = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // mode and function encodings
  localparam logic [1:0] GPR_MODE_INPUT = 2'h0;
  localparam logic [1:0] GPR_FUNC_ANALOG = 2'h0;
  localparam logic [1:0] GPR_FUNC_FLOAT  = 2'h1;
  localparam logic [1:0] GPR_FUNC_PULLED = 2'h2;

  // protection sequence states
  typedef enum logic [1:0] {
    GPR_SEQ_IDLE = 2'b00,
    GPR_SEQ_ONE  = 2'b01,
    GPR_SEQ_ZERO = 2'b10,
    GPR_SEQ_ONE2 = 2'b11
  } gpr_seq_state_type;

endpackage

// ---- design/gpr_pin_decode.sv ----
/*
  Per-pin decode of mode and function into pad controls.
  Assumes the pad cell resolves out/oe and the pull resistors itself.
*/
`timescale 1ns/1ps
module gpr_pin_decode (
  // configuration
  input  wire logic [1:0] pin_mode_field,
  input  wire logic [1:0] pin_function_field,
  input  wire logic       output_level_bit,
  // peripheral side
  input  wire logic       mux_out_bit,
  // pad side
  output logic            pad_out,
  output logic            pad_oe,
  output logic            pull_up_en,
  output logic            pull_down_en,
  output logic            analog_en,
  output logic            input_en,
  output logic [1:0]      drive_strength,
  output logic            mux_owned
);

  ////////////////////////////////////////////////////////////////////////////
  // mode and function split
  wire logic is_output  = (pin_mode_field != gpr_pkg::GPR_MODE_INPUT);
  wire logic open_drain = pin_function_field[0];
  wire logic from_mux   = pin_function_field[1];
  wire logic drive_val  = from_mux ? mux_out_bit : output_level_bit;

  // open drain only ever pulls low; a high level is left to the external pull-up
  assign pad_oe         = is_output & (~open_drain | ~drive_val);
  assign pad_out        = is_output & ~open_drain & drive_val;
  assign mux_owned      = is_output & from_mux;
  assign drive_strength = pin_mode_field;

  // input side: analog disconnects the digital path and the pulls
  assign analog_en    = ~is_output & (pin_function_field == gpr_pkg::GPR_FUNC_ANALOG);
  assign input_en     = ~analog_en;
  assign pull_up_en   = ~is_output & (pin_function_field == gpr_pkg::GPR_FUNC_PULLED)
                        & output_level_bit;
  assign pull_down_en = ~is_output & (pin_function_field == gpr_pkg::GPR_FUNC_PULLED)
                        & ~output_level_bit;

endmodule

// ---- design/gpr_protect_seq.sv ----
/*
  Write-protect arming sequence and the sticky per-pin lock bits.
  Assumes single-cycle write and read strobes from the bus slave.
*/
`timescale 1ns/1ps
module gpr_protect_seq (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // bus strobes and data
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic        protect_sequence_bit,
  input  wire logic [15:0] protect_enable_bits,
  // status
  output gpr_pkg::gpr_seq_state_type seq_state,
  output logic [15:0]      lock_q
);

  gpr_pkg::gpr_seq_state_type state_q;
  gpr_pkg::gpr_seq_state_type state_d;
  logic [15:0] held_en_q;
  logic [15:0] held_en_d;
  wire  logic  same_en  = (protect_enable_bits == held_en_q);
  wire  logic  fire     = rd_stb & (state_q == gpr_pkg::GPR_SEQ_ONE2);

  ////////////////////////////////////////////////////////////////////////////
  // sequence: any step out of order drops back to the start
  always_comb
  begin
    state_d   = state_q;
    held_en_d = held_en_q;
    if (wr_stb)
    begin
      if (protect_sequence_bit)
      begin
        if ((state_q == gpr_pkg::GPR_SEQ_ZERO) && same_en)
          state_d = gpr_pkg::GPR_SEQ_ONE2;
        else
        begin
          state_d   = gpr_pkg::GPR_SEQ_ONE;
          held_en_d = protect_enable_bits;
        end
      end
      else
      begin
        case (state_q)
          gpr_pkg::GPR_SEQ_ONE:  state_d = same_en ? gpr_pkg::GPR_SEQ_ZERO : gpr_pkg::GPR_SEQ_IDLE;
          default:               state_d = gpr_pkg::GPR_SEQ_IDLE;
        endcase
      end
    end
    else if (rd_stb)
      state_d = gpr_pkg::GPR_SEQ_IDLE;
  end

  // lock bits only ever accumulate; nothing but reset frees a pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q   <= gpr_pkg::GPR_SEQ_IDLE;
      held_en_q <= 16'h0000;
      lock_q    <= gpr_pkg::GPR_RST_LOCK;
    end
    else
    begin
      state_q   <= state_d;
      held_en_q <= held_en_d;
      lock_q    <= lock_q | (fire ? held_en_q : 16'h0000);
    end
  end

  assign seq_state = state_q;

endmodule

// ---- design/gpr_port_regs.sv ----
/*
  APB register bank for one 16-pin port: configuration, levels, set/clear,
  and write protection, with per-pin pad control decode.
  Assumes an APB master making word accesses and pads sampled on pclk.
*/
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module gpr_port_regs (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pads
  input  wire logic [15:0] pad_in,
  output logic [15:0]      pad_out,
  output logic [15:0]      pad_oe,
  output logic [15:0]      pull_up_en,
  output logic [15:0]      pull_down_en,
  output logic [15:0]      analog_en,
  output logic [15:0]      input_en,
  output logic [31:0]      drive_strength,
  // multiplexed peripherals
  input  wire logic [15:0] mux_out,
  output logic [15:0]      mux_owned
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] cfg_low_q;
  logic [31:0] cfg_low_d;
  logic [31:0] cfg_high_q;
  logic [31:0] cfg_high_d;
  logic [15:0] in_level_q;
  logic [15:0] out_level_q;
  logic [15:0] out_level_d;
  logic [16:0] protect_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [15:0] lock_q;
  gpr_pkg::gpr_seq_state_type seq_state;

  ////////////////////////////////////////////////////////////////////////////
  // address decode; zero wait states, data loaded in the setup cycle
  wire logic setup    = psel & ~penable;
  wire logic access   = psel & penable;
  wire logic hit_cfgl = (paddr == gpr_pkg::GPR_OFS_CFG_LOW);
  wire logic hit_cfgh = (paddr == gpr_pkg::GPR_OFS_CFG_HIGH);
  wire logic hit_in   = (paddr == gpr_pkg::GPR_OFS_IN_LEVEL);
  wire logic hit_out  = (paddr == gpr_pkg::GPR_OFS_OUT_LEVEL);
  wire logic hit_sc   = (paddr == gpr_pkg::GPR_OFS_SET_CLR);
  wire logic hit_clr  = (paddr == gpr_pkg::GPR_OFS_CLR_ONLY);
  wire logic hit_prot = (paddr == gpr_pkg::GPR_OFS_PROTECT);
  wire logic mapped   = hit_cfgl | hit_cfgh | hit_in | hit_out | hit_sc | hit_clr | hit_prot;
  wire logic wr_take  = access & pwrite & mapped;
  wire logic rd_take  = access & ~pwrite & mapped;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_q;

  // read mux; write-only words read as zero
  assign prdata_d = hit_cfgl ? cfg_low_q :
                    hit_cfgh ? cfg_high_q :
                    hit_in   ? {16'h0000, in_level_q} :
                    hit_out  ? {16'h0000, out_level_q} :
                    hit_prot ? {15'h0000, protect_q} :
                               32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // configuration writes, per pin, blocked once that pin is locked
  genvar g;
  generate
    for (g = 0; g < gpr_pkg::GPR_PINS_CFG; g++)
    begin : g_cfg
      assign cfg_low_d[g*4 +: 4]  = (wr_take & hit_cfgl & ~lock_q[g]) ? pwdata[g*4 +: 4]
                                                                      : cfg_low_q[g*4 +: 4];
      assign cfg_high_d[g*4 +: 4] = (wr_take & hit_cfgh & ~lock_q[g+8]) ? pwdata[g*4 +: 4]
                                                                        : cfg_high_q[g*4 +: 4];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // output level: direct write, set/clear and clear-only; set applied last so it wins
  wire logic [15:0] sc_set  = (wr_take & hit_sc) ? pwdata[15:0] : 16'h0000;
  wire logic [15:0] sc_clr  = (wr_take & hit_sc) ? pwdata[31:gpr_pkg::GPR_CLR_LSB] : 16'h0000;
  wire logic [15:0] co_clr  = (wr_take & hit_clr) ? pwdata[15:0] : 16'h0000;
  wire logic [15:0] out_wr  = (wr_take & hit_out) ? pwdata[15:0] : out_level_q;
  assign out_level_d = (out_wr & ~sc_clr & ~co_clr) | sc_set;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_low_q   <= gpr_pkg::GPR_RST_CFG;
      cfg_high_q  <= gpr_pkg::GPR_RST_CFG;
      in_level_q  <= 16'h0000;
      out_level_q <= gpr_pkg::GPR_RST_OUT;
      protect_q   <= 17'h0_0000;
      prdata_q    <= 32'h0000_0000;
    end
    else
    begin
      cfg_low_q   <= cfg_low_d;
      cfg_high_q  <= cfg_high_d;
      in_level_q  <= pad_in;
      out_level_q <= out_level_d;
      protect_q   <= (wr_take & hit_prot) ? pwdata[16:0] : protect_q;
      prdata_q    <= setup ? prdata_d : prdata_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection sequencer
  gpr_protect_seq u_seq (
    .pclk                 (pclk),
    .presetn              (presetn),
    .wr_stb               (wr_take & hit_prot),
    .rd_stb               (rd_take & hit_prot),
    .protect_sequence_bit (pwdata[gpr_pkg::GPR_SEQ_BIT]),
    .protect_enable_bits  (pwdata[15:0]),
    .seq_state            (seq_state),
    .lock_q               (lock_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pad decode for all sixteen pins
  wire logic [63:0] cfg_all = {cfg_high_q, cfg_low_q};
  generate
    for (g = 0; g < gpr_pkg::GPR_PINS; g++)
    begin : g_pin
      gpr_pin_decode u_pin (
        .pin_mode_field     (cfg_all[g*4+gpr_pkg::GPR_MODE_LSB +: 2]),
        .pin_function_field (cfg_all[g*4+gpr_pkg::GPR_FUNC_LSB +: 2]),
        .output_level_bit   (out_level_q[g]),
        .mux_out_bit        (mux_out[g]),
        .pad_out            (pad_out[g]),
        .pad_oe             (pad_oe[g]),
        .pull_up_en         (pull_up_en[g]),
        .pull_down_en       (pull_down_en[g]),
        .analog_en          (analog_en[g]),
        .input_en           (input_en[g]),
        .drive_strength     (drive_strength[g*2 +: 2]),
        .mux_owned          (mux_owned[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_CFG_LOW_WRITE: assert property (
    (wr_take && hit_cfgl && lock_q == 16'h0000) |=> (cfg_low_q == $past(pwdata)))
    else $error("unlocked low config write not stored");

  AST_LOCK_STICKY: assert property (
    ((lock_q & $past(lock_q)) == $past(lock_q)))
    else $error("lock bit released without reset");

  AST_IN_READ: assert property (
    (setup && hit_in && !pwrite) |=> (prdata[31:16] == 16'h0000 && prdata[15:0] == $past(in_level_q)))
    else $error("input level read wrong");

  AST_SET_CLEAR: assert property (
    (wr_take && hit_sc) |=> (out_level_q == (($past(out_level_q) & ~$past(pwdata[31:16])) | $past(pwdata[15:0]))))
    else $error("set/clear result wrong");

  AST_CLR_ONLY: assert property (
    (wr_take && hit_clr) |=> (out_level_q == ($past(out_level_q) & ~$past(pwdata[15:0]))))
    else $error("clear-only result wrong");

  AST_SEQ_RESTART: assert property (
    (wr_take && hit_prot && !pwdata[16] && seq_state != gpr_pkg::GPR_SEQ_ONE)
    |=> (seq_state == gpr_pkg::GPR_SEQ_IDLE))
    else $error("bad sequence step not restarted");

  // per-pin checks, so a sweep that visits pins in any order still reaches them
  generate
    for (g = 0; g < gpr_pkg::GPR_PINS; g++)
    begin : g_chk
      AST_LOCK_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
        lock_q[g] |=> $stable(cfg_all[g*4 +: 4]))
        else $error("locked pin configuration changed");

      AST_PUSH_PULL: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_all[g*4 +: 2] != 2'h0 && cfg_all[g*4+2 +: 2] == 2'h0)
        |-> (pad_oe[g] && pad_out[g] == out_level_q[g]))
        else $error("push-pull pin not driven from output level");

      AST_INPUT_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_all[g*4 +: 2] == 2'h0) |-> !pad_oe[g])
        else $error("input pin driven");

      AST_PULL_SEL: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_all[g*4 +: 2] == 2'h0 && cfg_all[g*4+2 +: 2] == 2'h2)
        |-> (pull_up_en[g] == out_level_q[g] && pull_down_en[g] != out_level_q[g]))
        else $error("pull selection wrong");
    end
  endgenerate

  COV_LOCK: cover property ($rose(lock_q[0]));
  COV_SC_BOTH: cover property (wr_take && hit_sc && (pwdata[15:0] & pwdata[31:16]) != 16'h0000);
  COV_UNMAPPED: cover property (pslverr);

endmodule

// ---- testbench/gpr_port_regs_tb.sv ----
/*
  Self-checking bench for the port register bank: APB tasks and directed tests.
  Assumes the package and design files are compiled first; one 40 MHz clock.
*/
`timescale 1ns/1ps
module gpr_port_regs_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] pad_in;
  logic [15:0] pad_out;
  logic [15:0] pad_oe;
  logic [15:0] pull_up_en;
  logic [15:0] pull_down_en;
  logic [15:0] analog_en;
  logic [15:0] input_en;
  logic [31:0] drive_strength;
  logic [15:0] mux_out;
  logic [15:0] mux_owned;
  int          fail_count;
  int          checked;
  logic [31:0] rdata;
  logic        err;
  logic [1:0]  m;
  logic [1:0]  f;
  logic        v;
  int          p;
  logic [31:0] w;
  logic [7:0]  a;

  gpr_port_regs DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .analog_en(analog_en), .input_en(input_en),
    .drive_strength(drive_strength), .mux_out(mux_out), .mux_owned(mux_owned)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  // compare and count; an unknown bit matches only an unknown bit
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits for pready without assuming a latency
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20)
      chk(32'h0, 32'h1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup never overwrites this release
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rdata, exp);
  endtask

  // expected pad controls of one pin, packed as compared below
  function automatic logic [31:0] exp_pad(logic [1:0] md, logic [1:0] fn, logic lv, logic mx);
    logic o;
    logic oe;
    logic val;
    val = fn[1] ? mx : lv;
    o = 1'b0;
    oe = 1'b0;
    if (md != 2'h0 && fn[0])
      oe = ~val;
    else if (md != 2'h0)
    begin
      o = val;
      oe = 1'b1;
    end
    return {23'h0, o, oe, (md == 2'h0 && fn == 2'h2) & lv, (md == 2'h0 && fn == 2'h2) & ~lv,
            md == 2'h0 && fn == 2'h0, !(md == 2'h0 && fn == 2'h0), md, md != 2'h0 && fn[1]};
  endfunction

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need well under 5000 cycles
  initial
  begin
    #500000;
    $display("ERROR at %0t: watchdog expired", $time);
    fail_count++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pad_in = 16'h0000;
    mux_out = 16'h0000;
    fail_count = 0;
    checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(gpr_pkg::GPR_OFS_CFG_LOW, 32'h4444_4444);
    rd(gpr_pkg::GPR_OFS_CFG_HIGH, 32'h4444_4444);
    rd(gpr_pkg::GPR_OFS_OUT_LEVEL, 32'h0000_0000);
    rd(gpr_pkg::GPR_OFS_PROTECT, 32'h0000_0000);
    rd(gpr_pkg::GPR_OFS_SET_CLR, 32'h0000_0000);
    rd(gpr_pkg::GPR_OFS_CLR_ONLY, 32'h0000_0000);
    chk({pad_oe, input_en}, 32'h0000_FFFF);
    $display("test reset_values done");

    // input word is read-only; a write must not disturb it
    pad_in <= 16'hA5C3;
    @(posedge pclk);
    apb(1'b1, gpr_pkg::GPR_OFS_IN_LEVEL, 32'hFFFF_FFFF);
    rd(gpr_pkg::GPR_OFS_IN_LEVEL, 32'h0000_A5C3);
    $display("test input_level done");

    // set/clear with set winning, then clear-only with reserved upper bits set
    apb(1'b1, gpr_pkg::GPR_OFS_OUT_LEVEL, 32'hFFFF_1234);
    rd(gpr_pkg::GPR_OFS_OUT_LEVEL, 32'h0000_1234);
    apb(1'b1, gpr_pkg::GPR_OFS_OUT_LEVEL, 32'h0000_00F0);
    apb(1'b1, gpr_pkg::GPR_OFS_SET_CLR, 32'h0030_0003);
    rd(gpr_pkg::GPR_OFS_OUT_LEVEL, 32'h0000_00C3);
    apb(1'b1, gpr_pkg::GPR_OFS_SET_CLR, 32'h0101_0100);
    rd(gpr_pkg::GPR_OFS_OUT_LEVEL, 32'h0000_01C2);
    apb(1'b1, gpr_pkg::GPR_OFS_CLR_ONLY, 32'hFFFF_0042);
    rd(gpr_pkg::GPR_OFS_OUT_LEVEL, 32'h0000_0180);
    $display("test set_clear done");

    // every mode/function pair, both level values, spread over all pins
    for (int i = 0; i < 64; i++)
    begin
      m = i[1:0];
      f = i[3:2];
      v = i[4];
      p = (i * 7) % 16;
      w = 32'h4444_4444;
      w[4 * (p % 8) +: 4] = {f, m};
      a = (p < 8) ? gpr_pkg::GPR_OFS_CFG_LOW : gpr_pkg::GPR_OFS_CFG_HIGH;
      mux_out <= {16{~v}};
      apb(1'b1, gpr_pkg::GPR_OFS_OUT_LEVEL, {16'h0, {16{v}}});
      apb(1'b1, a, w);
      rd(a, w);
      chk({23'h0, pad_out[p] & (m != 2'h0), pad_oe[p], pull_up_en[p], pull_down_en[p], analog_en[p],
           input_en[p], drive_strength[2 * p +: 2], mux_owned[p]}, exp_pad(m, f, v, ~v));
    end
    apb(1'b1, gpr_pkg::GPR_OFS_CFG_LOW, 32'h4444_4444);
    apb(1'b1, gpr_pkg::GPR_OFS_CFG_HIGH, 32'h4444_4444);
    $display("test pin_decode done");

    // broken sequence: enable bits change, then a read cuts it short
    apb(1'b1, gpr_pkg::GPR_OFS_PROTECT, 32'h0001_0004);
    apb(1'b1, gpr_pkg::GPR_OFS_PROTECT, 32'h0000_0008);
    apb(1'b1, gpr_pkg::GPR_OFS_PROTECT, 32'h0000_0004);
    apb(1'b1, gpr_pkg::GPR_OFS_PROTECT, 32'h0001_0004);
    rd(gpr_pkg::GPR_OFS_PROTECT, 32'h0001_0004);
    apb(1'b1, gpr_pkg::GPR_OFS_CFG_LOW, 32'h0000_0000);
    rd(gpr_pkg::GPR_OFS_CFG_LOW, 32'h0000_0000);
    apb(1'b1, gpr_pkg::GPR_OFS_CFG_LOW, 32'h4444_4444);
    // proper sequence locks pins 0 and 1
    apb(1'b1, gpr_pkg::GPR_OFS_PROTECT, 32'h0001_0003);
    apb(1'b1, gpr_pkg::GPR_OFS_PROTECT, 32'h0000_0003);
    apb(1'b1, gpr_pkg::GPR_OFS_PROTECT, 32'h0001_0003);
    rd(gpr_pkg::GPR_OFS_PROTECT, 32'h0001_0003);
    apb(1'b1, gpr_pkg::GPR_OFS_CFG_LOW, 32'h1111_1111);
    rd(gpr_pkg::GPR_OFS_CFG_LOW, 32'h1111_1144);
    $display("test protection done");

    // a mapped access raises no error; an unmapped one is refused and reads zero
    chk({31'h0, err}, 32'h0);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h1C, 32'h0);
    chk(rdata, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test unmapped done");

    // a reset in mid-run releases the lock
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, gpr_pkg::GPR_OFS_CFG_LOW, 32'h0000_0000);
    rd(gpr_pkg::GPR_OFS_CFG_LOW, 32'h0000_0000);
    rd(gpr_pkg::GPR_OFS_PROTECT, 32'h0000_0000);
    $display("test reset_unlock done");
    tally_and_finish();
  end
endmodule
